// *** src/secl_pkg.sv ***
package secl_pkg;

	// mode pin decode
	localparam logic [1:0] MODE_SERIAL_PINS = 2'h3;
	localparam int         MODE_UPPER_POS   = 1;

	// serial header layout
	localparam int          LEAD_ONES_LEN   = 8;
	localparam logic [3:0]  PREAMBLE_CODE   = 4'h2;
	localparam int          PREAMBLE_LEN    = 4;
	localparam int          LENGTH_BITS     = 24;
	localparam int          SEPARATOR_LEN   = 4;

	// frame layout defaults
	localparam int          FRAME_BITS_DEF  = 32;
	localparam int          FRAME_COUNT_DEF = 8;
	localparam logic [1:0]  FRAME_START     = 2'h1;
	localparam int          FRAME_START_LEN = 2;
	localparam logic [3:0]  FRAME_CHECK     = 4'hF;
	localparam int          FRAME_CHECK_LEN = 4;

	// release delay after last bit, in config clock cycles
	localparam int          RELEASE_DELAY   = 2;

	// reset values
	localparam logic        CHAIN_OUT_RST   = 1'b1;
	localparam logic [23:0] LENGTH_RST      = 24'h000000;

	// load state machine, gray coded along the usual path
	typedef enum logic [2:0] {
		SECL_IDLE   = 3'h0,
		SECL_HEADER = 3'h1,
		SECL_LOAD   = 3'h3,
		SECL_PASS   = 3'h2,
		SECL_START  = 3'h6,
		SECL_ACTIVE = 3'h7
	} secl_state_type;

	// status bundle carried to the core clock domain
	typedef struct packed {
		logic       express;
		logic       frame_error;
		logic       memory_full;
		logic       io_release;
	} secl_status_type;

	// config pin bundle
	typedef struct packed {
		logic       mode_pin_upper;
		logic       mode_pin_lower;
		logic       chain_select_in;
		logic       serial_data;
		logic [7:0] config_byte_bus;
	} secl_pins_type;

endpackage

// *** src/secl_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; a change is taken once stages two and three agree
module secl_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, hold_r;
	logic [WIDTH-1:0] hold_nxt;

	// keep value while stages two and three disagree
	always_comb begin
		hold_nxt = hold_r;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				hold_nxt[i] = s3_r[i];
			end
		end
	end

	// register the chain
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r   <= '0;
			s2_r   <= '0;
			s3_r   <= '0;
			hold_r <= '0;
		end else begin
			s1_r   <= async_i;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			hold_r <= hold_nxt;
		end
	end

	assign sync_o = hold_r;
endmodule // secl_sync

`default_nettype wire

// *** src/secl_loader.sv ***
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - unconnected mode pins read high by pull-up, selecting slave bit-serial loading.
// - incoming data is forwarded on chain output, retimed to config clock.
// - header passes through; device captures it after seeing preamble 0010.
// - after length count, chain output held high until own frames absorbed.
// - after own frames, further start bits and data pass unchanged.
// - count config clocks; start-up when count equals received 24-bit length.
// - user pins released two config clocks after final configuration bit.
// - express mode takes one byte per config clock into shift registers.
// - express mode skips CRC and length count, still checks constant fields.
// - express mode chosen when upper mode pin is 0.
// - express frames accepted only while chain select high and memory not full.
// - express chain output low after header until memory full, then high.
// - config-complete pull-up enabled by default, disable option available.
// - serial stream: ones, preamble, length, separator, frames with start and check.
// - express mode becomes active two config clocks after config-complete goes high.
module secl_loader
	import secl_pkg::*;
#(
	parameter int FRAME_BITS  = FRAME_BITS_DEF,
	parameter int FRAME_COUNT = FRAME_COUNT_DEF
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  config_clock_i,
	input  wire secl_pkg::secl_pins_type pins_i,
	input  wire logic                  done_pullup_dis_i,
	input  wire logic                  done_in_i,
	output logic                       chain_out_o,
	output logic                       done_o,
	output logic                       done_oe_n_o,
	output logic                       done_pullup_en_o,
	output logic                       io_release_o,
	output logic                       frame_error_o,
	output logic                       express_o,
	output logic [FRAME_BITS-1:0]      frame_data_o,
	output logic                       frame_valid_o
);
	import secl_pkg::*;

	localparam int FRAME_BYTES = FRAME_BITS / 8;
	localparam int FCW         = $clog2(FRAME_BITS + 1);
	localparam int NCW         = $clog2(FRAME_COUNT + 1);

	// link-domain state
	secl_state_type      state_r, state_nxt;
	logic [LENGTH_BITS-1:0] length_r, length_nxt;
	logic [LENGTH_BITS-1:0] clk_cnt_r, clk_cnt_nxt;
	logic [LENGTH_BITS-1:0] hdr_cnt_r, hdr_cnt_nxt;
	logic [FRAME_BITS-1:0]  shift_r, shift_nxt;
	logic [FCW-1:0]         bit_cnt_r, bit_cnt_nxt;
	logic [NCW-1:0]         frm_cnt_r, frm_cnt_nxt;
	logic [1:0]             rel_cnt_r, rel_cnt_nxt;
	logic                   chain_r, chain_nxt;
	logic                   err_r, err_nxt;
	logic                   full_r, full_nxt;
	logic                   rel_r, rel_nxt;
	logic                   done_r, done_nxt;
	logic                   fv_tog_r, fv_tog_nxt;
	logic [FRAME_BITS-1:0]  frame_r, frame_nxt;
	logic                   express_r;
	logic                   mode_seen_r;

	// core-domain state
	secl_status_type        stat_sync;
	logic [2:0]             fv_sync_r;
	logic [FRAME_BITS-1:0]  frame_core_r, frame_core_nxt;
	logic                   fvalid_r, fvalid_nxt;

	logic [FRAME_BITS-1:0]  frame_in;
	logic                   frame_end;
	logic                   byte_take;

	// mode latched on first config clock after reset; express when upper pin is 0
	always_ff @(posedge config_clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			express_r   <= 1'b0;
			mode_seen_r <= 1'b0;
		end else if (!mode_seen_r) begin
			express_r   <= !pins_i.mode_pin_upper;
			mode_seen_r <= 1'b1;
		end
	end

	// serial bit shifted in, or a whole byte in express mode
	always_comb begin
		if (express_r) begin
			// cast keeps the low bits, so an 8-bit frame needs no empty slice
			frame_in = FRAME_BITS'({shift_r, pins_i.config_byte_bus});
		end else begin
			frame_in = FRAME_BITS'({shift_r, pins_i.serial_data});
		end
	end

	assign byte_take = express_r && pins_i.chain_select_in && !full_r;
	assign frame_end = express_r ? (bit_cnt_r == FCW'(FRAME_BYTES - 1))
	                             : (bit_cnt_r == FCW'(FRAME_BITS - 1));

	// next-state logic of the loader
	always_comb begin
		state_nxt   = state_r;
		length_nxt  = length_r;
		clk_cnt_nxt = clk_cnt_r + 1'b1;
		hdr_cnt_nxt = hdr_cnt_r;
		shift_nxt   = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		frm_cnt_nxt = frm_cnt_r;
		rel_cnt_nxt = rel_cnt_r;
		chain_nxt   = chain_r;
		err_nxt     = err_r;
		full_nxt    = full_r;
		rel_nxt     = rel_r;
		done_nxt    = done_r;
		fv_tog_nxt  = fv_tog_r;
		frame_nxt   = frame_r;
		case (state_r)
			SECL_IDLE: begin
				shift_nxt = frame_in;
				if (express_r) begin
					chain_nxt = 1'b1;
					if (pins_i.chain_select_in) begin
						state_nxt   = SECL_HEADER;
						hdr_cnt_nxt = LENGTH_BITS'(1); // byte taken with select high is header byte one
					end
				end else begin
					chain_nxt = pins_i.serial_data;
					if (frame_in[PREAMBLE_LEN-1:0] == PREAMBLE_CODE) begin
						state_nxt   = SECL_HEADER;
						hdr_cnt_nxt = '0;
					end
				end
			end
			SECL_HEADER: begin
				hdr_cnt_nxt = hdr_cnt_r + 1'b1;
				if (express_r) begin
					// 24 fill bits = 3 bytes, no length used
					if (hdr_cnt_r == LENGTH_BITS'(LENGTH_BITS / 8 - 1)) begin
						state_nxt   = SECL_LOAD;
						chain_nxt   = 1'b0;
						bit_cnt_nxt = '0;
					end
				end else begin
					chain_nxt = pins_i.serial_data;
					if (hdr_cnt_r < LENGTH_BITS'(LENGTH_BITS)) begin
						length_nxt = {length_r[LENGTH_BITS-2:0], pins_i.serial_data};
					end
					if (hdr_cnt_r == LENGTH_BITS'(LENGTH_BITS + SEPARATOR_LEN - 1)) begin
						state_nxt   = SECL_LOAD;
						bit_cnt_nxt = '0;
						chain_nxt   = 1'b1;
					end
				end
			end
			SECL_LOAD: begin
				if (!express_r) begin
					chain_nxt = 1'b1;
				end
				if (!express_r || byte_take) begin
					shift_nxt   = frame_in;
					bit_cnt_nxt = bit_cnt_r + 1'b1;
					if (frame_end) begin
						bit_cnt_nxt = '0;
						frame_nxt   = frame_in;
						fv_tog_nxt  = !fv_tog_r;
						// constant fields: start at top, check at bottom
						if (frame_in[FRAME_BITS-1 -: FRAME_START_LEN] != FRAME_START ||
						    frame_in[FRAME_CHECK_LEN-1:0] != FRAME_CHECK) begin
							err_nxt = 1'b1;
						end
						frm_cnt_nxt = frm_cnt_r + 1'b1;
						if (frm_cnt_r == NCW'(FRAME_COUNT - 1)) begin
							full_nxt  = 1'b1;
							state_nxt = express_r ? SECL_START : SECL_PASS;
							if (express_r) begin
								chain_nxt = 1'b1;
								done_nxt  = 1'b1;
							end
						end
					end
				end
			end
			SECL_PASS: begin
				chain_nxt = pins_i.serial_data;
				if (clk_cnt_r + 1'b1 == length_r) begin
					state_nxt   = SECL_START;
					done_nxt    = 1'b1;
					rel_cnt_nxt = '0;
				end
			end
			SECL_START: begin
				if (!express_r) begin
					chain_nxt = pins_i.serial_data;
				end
				if (!express_r || done_in_i) begin
					rel_cnt_nxt = rel_cnt_r + 1'b1;
					if (rel_cnt_r == 2'(RELEASE_DELAY - 1)) begin
						rel_nxt   = 1'b1;
						state_nxt = SECL_ACTIVE;
					end
				end
			end
			SECL_ACTIVE: begin
				if (!express_r) begin
					chain_nxt = pins_i.serial_data;
				end
			end
			default: begin
				state_nxt = SECL_IDLE;
			end
		endcase
	end

	// link-domain registers
	always_ff @(posedge config_clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r   <= SECL_IDLE;
			length_r  <= LENGTH_RST;
			clk_cnt_r <= '0;
			hdr_cnt_r <= '0;
			shift_r   <= '0;
			bit_cnt_r <= '0;
			frm_cnt_r <= '0;
			rel_cnt_r <= '0;
			chain_r   <= CHAIN_OUT_RST;
			err_r     <= 1'b0;
			full_r    <= 1'b0;
			rel_r     <= 1'b0;
			done_r    <= 1'b0;
			fv_tog_r  <= 1'b0;
			frame_r   <= '0;
		end else begin
			state_r   <= state_nxt;
			length_r  <= length_nxt;
			clk_cnt_r <= clk_cnt_nxt;
			hdr_cnt_r <= hdr_cnt_nxt;
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			frm_cnt_r <= frm_cnt_nxt;
			rel_cnt_r <= rel_cnt_nxt;
			chain_r   <= chain_nxt;
			err_r     <= err_nxt;
			full_r    <= full_nxt;
			rel_r     <= rel_nxt;
			done_r    <= done_nxt;
			fv_tog_r  <= fv_tog_nxt;
			frame_r   <= frame_nxt;
		end
	end

	// pins driven straight from link-domain flops; pull-up enable straight from its input
	assign chain_out_o      = chain_r;
	assign done_o           = done_r;
	assign done_oe_n_o      = done_r; // drive low until done, then release
	assign done_pullup_en_o = !done_pullup_dis_i;

	// status levels into the core domain
	secl_sync #(
		.WIDTH (4)
	) u_stat_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    ({express_r, err_r, full_r, rel_r}),
		.sync_o     (stat_sync)
	);

	// frame toggle crossing and word capture in the core domain
	always_comb begin
		frame_core_nxt = frame_core_r;
		fvalid_nxt     = 1'b0;
		if (fv_sync_r[2] != fv_sync_r[1]) begin
			frame_core_nxt = frame_r; // stable for a whole frame time
			fvalid_nxt     = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fv_sync_r    <= '0;
			frame_core_r <= '0;
			fvalid_r     <= 1'b0;
		end else begin
			fv_sync_r    <= {fv_sync_r[1:0], fv_tog_r};
			frame_core_r <= frame_core_nxt;
			fvalid_r     <= fvalid_nxt;
		end
	end

	assign io_release_o  = stat_sync.io_release;
	assign frame_error_o = stat_sync.frame_error;
	assign express_o     = stat_sync.express;
	assign frame_data_o  = frame_core_r;
	assign frame_valid_o = fvalid_r;
endmodule // secl_loader

`default_nettype wire

// *** bench/secl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// pin checker for the loader, both clock domains
module secl_props
	import secl_pkg::*;
#(
	parameter int FRAME_BITS  = FRAME_BITS_DEF,
	parameter int FRAME_COUNT = FRAME_COUNT_DEF
) (
	input wire logic                    core_clk_i,
	input wire logic                    rst_n_i,
	input wire logic                    config_clock_i,
	input wire secl_pkg::secl_pins_type pins_i,
	input wire logic                    done_pullup_dis_i,
	input wire logic                    done_in_i,
	input wire logic                    chain_out_o,
	input wire logic                    done_o,
	input wire logic                    done_oe_n_o,
	input wire logic                    done_pullup_en_o,
	input wire logic                    io_release_o,
	input wire logic                    frame_error_o,
	input wire logic                    express_o,
	input wire logic [FRAME_BITS-1:0]   frame_data_o,
	input wire logic                    frame_valid_o
);
	// core domain status
	pullup_en_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		done_pullup_en_o == !done_pullup_dis_i) else $error("pull-up enable wrong");
	io_needs_done_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		io_release_o |-> done_o) else $error("io released before done");
	pulse_once_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		frame_valid_o |=> !frame_valid_o) else $error("frame valid longer than one cycle");
	error_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		frame_error_o |=> frame_error_o) else $error("frame error dropped");
	mode_kept_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!$fell(express_o)) else $error("express mode lost");
	// link domain outputs
	drive_low_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
		!done_oe_n_o |-> !done_o) else $error("done driven while high");
	done_hold_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
		done_o |=> done_o) else $error("done dropped");
	release_delay_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
		$rose(done_o) |-> !io_release_o [*2] ##[1:12] io_release_o) else $error("io release timing");
	express_full_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
		express_o && done_o |-> chain_out_o) else $error("chain low after memory full");
	serial_retime_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
		!express_o && !chain_out_o |-> !$past(pins_i.serial_data)) else $error("chain output not retimed");
endmodule // secl_props

bind secl_loader secl_props #(.FRAME_BITS(FRAME_BITS), .FRAME_COUNT(FRAME_COUNT)) u_secl_props (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .config_clock_i(config_clock_i), .pins_i(pins_i),
	.done_pullup_dis_i(done_pullup_dis_i), .done_in_i(done_in_i), .chain_out_o(chain_out_o),
	.done_o(done_o), .done_oe_n_o(done_oe_n_o), .done_pullup_en_o(done_pullup_en_o),
	.io_release_o(io_release_o), .frame_error_o(frame_error_o), .express_o(express_o),
	.frame_data_o(frame_data_o), .frame_valid_o(frame_valid_o));
`default_nettype wire

// *** bench/secl_source.sv ***
`timescale 1ns/100ps
`default_nettype none
// upstream source; its clock runs only while a unit is sent
module secl_source
	import secl_pkg::*;
(
	input  wire logic                   mode_i,
	input  wire logic                   mode_lo_i,
	input  wire logic                   cs_i,
	output logic                        config_clock_o,
	output var secl_pkg::secl_pins_type pins_o
);
	logic       dat_r;
	logic [7:0] bus_r;
	// straps from the board; select driven by the bench, high from the third express byte to the end of the run
	// one data line, free to fan out to several loaders in parallel
	assign pins_o = '{mode_i, mode_lo_i, cs_i, dat_r, bus_r};
	initial begin
		config_clock_o = 1'b0;
		dat_r = 1'b1;
		bus_r = 8'hFF;
	end
	// one 32 ns period: data set in the low phase, held over the rising edge
	task automatic send(input logic [7:0] v);
		#1 dat_r = v[0];
		bus_r = v;
		#15 config_clock_o = 1'b1;
		#16 config_clock_o = 1'b0;
		// data inverted at the falling edge, so stale data is not left on the lines
		dat_r = ~v[0];
		bus_r = ~v;
	endtask
endmodule // secl_source
`default_nettype wire

// *** bench/serial_express_config_loader_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_express_config_loader_bench;
	import secl_pkg::*;
	typedef struct packed {logic [23:0] val; logic [4:0] n; logic held;} secl_row_type;
	logic          core_clk, rst_n, pud, cfg_clk, chain, done, done_oe_n, pu_en, io_rel, ferr, expr, fval, cs;
	logic          done_wire, hold_done;
	logic [7:0]    fdata;
	logic [1:0]    mode;
	secl_pins_type pins;
	int            fails, total_checks, cycles;
	logic [7:0]    frames [$];
	// lead bit, ones, preamble, length 76, separator, two own frames, pass-through
	secl_row_type rows [9] = '{'{24'h1, 5'h1, 1'h0}, '{24'hFF, 5'h8, 1'h0}, '{24'h2, 5'h4, 1'h0},
		'{24'h4C, 5'h18, 1'h0}, '{24'hF, 5'h4, 1'h0}, '{24'h5F, 5'h8, 1'h1}, '{24'h4F, 5'h8, 1'h1},
		'{24'h1, 5'h1, 1'h0}, '{24'h4F30, 5'h10, 1'h0}};
	// shared config-complete wire with a board pull-up; hold_done is a later device still loading
	assign done_wire = hold_done ? 1'b0 : (done_oe_n ? 1'b1 : done);
	secl_source u_secl_source (.mode_i(mode[1]), .mode_lo_i(mode[0]), .cs_i(cs), .config_clock_o(cfg_clk),
		.pins_o(pins));
	secl_loader #(.FRAME_BITS(8), .FRAME_COUNT(2)) u_secl_loader (.core_clk_i(core_clk), .rst_n_i(rst_n),
		.config_clock_i(cfg_clk), .pins_i(pins), .done_pullup_dis_i(pud), .done_in_i(done_wire),
		.chain_out_o(chain), .done_o(done), .done_oe_n_o(done_oe_n), .done_pullup_en_o(pu_en),
		.io_release_o(io_rel), .frame_error_o(ferr), .express_o(expr), .frame_data_o(fdata), .frame_valid_o(fval));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// frame collector and run ceiling, sampled mid-cycle
	always @(negedge core_clk) begin
		cycles++;
		if (fval === 1'b1)
			frames.push_back(fdata);
		if (cycles == 1000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
		end
	endtask
	task automatic sbit(input logic b, input logic held);
		u_secl_source.send({8{b}});
		chk("chain_out", chain, held ? 1'b1 : b);
	endtask
	task automatic xbyte(input logic [7:0] v, input logic c, input logic ch, input logic dn);
		cs = c;
		u_secl_source.send(v);
		chk("chain_out", chain, ch);
		chk("done", done, dn);
		// one-byte frames need time to cross to the core clock
		repeat (5) @(negedge core_clk);
	endtask
	task automatic do_reset(input logic [1:0] m);
		@(negedge core_clk);
		rst_n = 1'b0;
		mode = m;
		cs = 1'b0;
		u_secl_source.send(8'hFF);
		u_secl_source.send(8'hFF);
		chk("chain_out", chain, 1'b1);
		chk("done", done, 1'b0);
		chk("done_oe_n", done_oe_n, 1'b0);
		// source has sent two clocks in reset; the loader is released only now
		@(negedge core_clk) rst_n = 1'b1;
		frames.delete();
	endtask
	task automatic rel_check();
		u_secl_source.send(8'h00);
		u_secl_source.send(8'h00);
		repeat (6) @(negedge core_clk);
		chk("io_release", io_rel, 1'b1);
		u_secl_source.send(8'h00);
		u_secl_source.send(8'h00);
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		pud = 1'b0;
		hold_done = 1'b0;
		mode = 2'h3;
		cs = 1'b0;
		fails = 0;
		total_checks = 0;
		cycles = 0;
		// serial load, mode pins pulled high
		do_reset(2'h3);
		foreach (rows[r])
			for (int i = rows[r].n - 1; i >= 0; i--)
				sbit(rows[r].val[i], rows[r].held);
		chk("done", done, 1'b0);
		sbit(1'b0, 1'b0);
		sbit(1'b0, 1'b0);
		chk("done", done, 1'b1);
		chk("io_release", io_rel, 1'b0);
		rel_check();
		chk("frames", frames.size(), 32'h2);
		chk("frame0", frames[0], 8'h5F);
		chk("frame1", frames[1], 8'h4F);
		chk("express", expr, 1'b0);
		chk("frame_error", ferr, 1'b0);
		$display("serial chain test done");
		// express load, both mode pins low, two bytes ignored while deselected, one refused once memory full
		do_reset(2'h0);
		xbyte(8'hFF, 1'b0, 1'b1, 1'b0);
		xbyte(8'h00, 1'b0, 1'b1, 1'b0);
		xbyte(8'hF0, 1'b1, 1'b1, 1'b0);
		xbyte(8'hF0, 1'b1, 1'b1, 1'b0);
		xbyte(8'hF0, 1'b1, 1'b0, 1'b0);
		xbyte(8'h00, 1'b1, 1'b0, 1'b0);
		// another device on the shared wire still holds config-complete low
		@(negedge core_clk) hold_done = 1'b1;
		xbyte(8'h5F, 1'b1, 1'b1, 1'b1);
		xbyte(8'h4F, 1'b1, 1'b1, 1'b1);
		u_secl_source.send(8'h00);
		u_secl_source.send(8'h00);
		repeat (6) @(negedge core_clk);
		chk("io_release", io_rel, 1'b0);
		@(negedge core_clk) hold_done = 1'b0;
		rel_check();
		chk("frames", frames.size(), 32'h2);
		chk("frame0", frames[0], 8'h00);
		chk("frame1", frames[1], 8'h5F);
		chk("express", expr, 1'b1);
		chk("frame_error", ferr, 1'b1);
		chk("done_oe_n", done_oe_n, 1'b1);
		chk("pullup_en", pu_en, 1'b1);
		@(negedge core_clk) pud = 1'b1;
		@(negedge core_clk) chk("pullup_en", pu_en, 1'b0);
		$display("express chain test done");
		end_of_test();
	end
endmodule // serial_express_config_loader_bench
`default_nettype wire
